// ---- verilog/clock_sysref_control_regs.sv ----
// clock and alignment-reference control registers with position status
// assumes the serial port engine delivers single-cycle byte requests on clk_i
// assumes the delay-line taps are held steady around each reference edge
// position bytes are read live; a capture between byte reads tears the word
//
// Overview of operation
// - reference drives sample LSB when both enables set
// - timestamp only valid with downconverter bypassed
// - bit 2 selects device clock PECL mode
// - bit 1 selects reference input PECL mode
// - bit 0 inverts reference before alignment
// - first control byte at 0x2A, reset 0x00
// - second control byte resets 0x11, reserved bits writable
// - bit 4 selects high feedback gain
// - bit 2 enables analog supply noise suppression
// - bits 1:0 one-hot sample clock delay
// - 24-bit reference edge position status
// - position at 0x2C, read-only, undefined before capture
// - 4-bit delay select; zero allows auto calibration
// - fine bit shrinks windowing delay steps
`timescale 1ns/1ps
module clock_sysref_control_regs
  import clk_ref_pkg::*;
(
  input wire logic clk_i,                                // 40 MHz clock
  input wire logic rst_i,                                // async reset, high
  input wire logic ce_i,                                 // clock enable
  input wire reg_req_t req_i,                            // register request
  output logic [7:0] rdata_o,                            // read data
  input wire logic timestamp_global_enable_i,            // general timestamp enable
  input wire logic ddc_bypass_i,                         // downconverter bypassed
  input wire logic [REF_SEL_W-1:0] reference_delay_select_i, // delay select field
  input wire logic reference_window_fine_i,              // zoom bit
  input wire logic ref_i,                                // reference pin level
  input wire logic [POS_W-1:0] ref_taps_i,               // delay-line taps
  input wire logic [SAMPLE_W-1:0] sample_i,              // converter sample
  output logic [SAMPLE_W-1:0] sample_o,                  // sample with timestamp
  output ctrl_one_t ctrl_one_o,                          // first control fields
  output ctrl_two_t ctrl_two_o,                          // second control fields
  output logic ref_aligned_o,                            // corrected reference
  output logic [REF_SEL_W-1:0] ref_delay_sel_o,          // applied capture delay
  output logic auto_cal_allowed_o,                       // auto calibration usable
  output logic window_fine_o,                            // fine step select
  output logic pos_valid_o                               // position captured
);
  // stored bytes; reserved bits are kept so they read back as written
  logic [7:0] ctrl_one_ff;
  logic [7:0] ctrl_two_ff;
  logic [7:0] rdata_ff;
  logic [SAMPLE_W-1:1] sample_hi_ff;
  logic sample_lsb_ff;
  // position word and corrected reference from the capture stage
  logic [POS_W-1:0] pos;
  logic ref_level;

  // the read path hands the position out as exactly three bytes
  if (POS_W != 24) begin : g_bad_pos_w
    $error("position width must be three bytes");
  end

  // bit 0 carries the timestamp, so one bit at least must pass through
  if (SAMPLE_W < 2) begin : g_bad_sample_w
    $error("sample width too small");
  end

  // the top field of each byte, bits 3 and 4, must lie inside its byte
  if (TS_REF_BIT > 7 || FB_GAIN_BIT > 7) begin : g_bad_field_pos
    $error("field position outside the byte");
  end

  // delay field must sit below the noise suppress bit
  if (SCLK_DEL_LSB + SCLK_DEL_W > NOISE_SUPP_BIT) begin : g_bad_delay_field
    $error("sample clock delay field overlaps");
  end

  // the delay field must leave reset with a tap selected
  if (CLOCK_CONTROL_TWO_RST[SCLK_DEL_LSB +: SCLK_DEL_W] == {SCLK_DEL_W{1'b0}}) begin : g_bad_delay_rst
    $error("sample clock delay reset selects no tap");
  end

  // the address must be wide enough to tell the map apart
  if (ADDR_W < 6) begin : g_bad_addr_w
    $error("address too narrow for the map");
  end

  // ce_i low makes the port deaf as well as freezing state,
  // so a request offered in a frozen cycle is simply lost
  wire req_wr = ce_i & req_i.wr;
  wire req_rd = ce_i & req_i.rd;

  // full-width compare, so no alias of the map answers
  wire hit_one = (req_i.addr == CLOCK_CONTROL_ONE_OFS);
  wire hit_two = (req_i.addr == CLOCK_CONTROL_TWO_OFS);
  wire hit_pos_lo = (req_i.addr == REF_POS_B0_OFS);
  wire hit_pos_mid = (req_i.addr == REF_POS_B1_OFS);
  wire hit_pos_hi = (req_i.addr == REF_POS_B2_OFS);

  // write strobes; the position bytes have no write path at all
  // reserved bits are stored like any other bit
  wire wr_one = req_wr & hit_one;
  wire wr_two = req_wr & hit_two;
  wire [7:0] nxt_ctrl_one = wr_one ? req_i.wdata : ctrl_one_ff;
  wire [7:0] nxt_ctrl_two = wr_two ? req_i.wdata : ctrl_two_ff;

  // read sources are or-ed; an unmapped address reads zero
  // position bytes are served live from the capture stage
  wire [7:0] rd_one = hit_one ? ctrl_one_ff : 8'h00;
  wire [7:0] rd_two = hit_two ? ctrl_two_ff : 8'h00;
  wire [7:0] rd_pos_lo = hit_pos_lo ? pos[7:0] : 8'h00;
  wire [7:0] rd_pos_mid = hit_pos_mid ? pos[15:8] : 8'h00;
  wire [7:0] rd_pos_hi = hit_pos_hi ? pos[23:16] : 8'h00;
  wire [7:0] rd_mux =
    rd_one |
    rd_two |
    rd_pos_lo |
    rd_pos_mid |
    rd_pos_hi;
  // a read and a write in one cycle return the old byte
  wire [7:0] nxt_rdata = req_rd ? rd_mux : rdata_ff;

  // first control byte; reset leaves every receiver in its default mode
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_one_ff <= CLOCK_CONTROL_ONE_RST;
    end else if (ce_i) begin
      ctrl_one_ff <= nxt_ctrl_one;
    end
  end

  // second control byte
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_two_ff <= CLOCK_CONTROL_TWO_RST;
    end else if (ce_i) begin
      ctrl_two_ff <= nxt_ctrl_two;
    end
  end

  // read data holds until the next read
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= 8'h00;
    end else if (ce_i) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // field taps of the stored bytes
  // bit 3 alone does nothing; see the timestamp gate below
  wire ts_ref_sel = ctrl_one_ff[TS_REF_BIT];
  wire dev_clk_pecl = ctrl_one_ff[DEV_PECL_BIT];
  wire ref_in_pecl = ctrl_one_ff[REF_PECL_BIT];
  wire ref_invert = ctrl_one_ff[REF_INV_BIT];
  wire fb_gain_high = ctrl_two_ff[FB_GAIN_BIT];
  wire noise_suppress = ctrl_two_ff[NOISE_SUPP_BIT];
  wire [SCLK_DEL_W-1:0] sclk_delay = ctrl_two_ff[SCLK_DEL_LSB +: SCLK_DEL_W];

  // the position is undefined until the first capture; here it starts
  // at zero and pos_valid_o tells the two apart
  // invert acts ahead of the edge detector, so flipping it while the
  // reference idles can itself be taken as an edge
  ref_edge_capture #(
    .TAP_W(POS_W)
  ) u_capture (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .ref_i(ref_i),
    .taps_i(ref_taps_i),
    .invert_i(ref_invert),
    .ref_level_o(ref_level),
    .pos_o(pos),
    .pos_valid_o(pos_valid_o)
  );

  // lsb replacement only when the downconverter is bypassed;
  // the mark is the registered reference, one clock behind the sync stage
  wire ts_allowed = timestamp_global_enable_i & ddc_bypass_i;
  wire ts_on = ts_ref_sel & ts_allowed;
  wire nxt_sample_lsb = ts_on ? ref_level : sample_i[0];
  wire [SAMPLE_W-1:1] nxt_sample_hi = sample_i[SAMPLE_W-1:1];

  // upper sample bits pass one register stage untouched
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sample_hi_ff <= '0;
    end else if (ce_i) begin
      sample_hi_ff <= nxt_sample_hi;
    end
  end

  // lsb stage: converter bit or the corrected reference
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sample_lsb_ff <= 1'b0;
    end else if (ce_i) begin
      sample_lsb_ff <= nxt_sample_lsb;
    end
  end

  // registered data outputs
  assign sample_o = {sample_hi_ff, sample_lsb_ff};
  assign rdata_o = rdata_ff;
  assign ref_aligned_o = ref_level;

  // control fields straight from the stored bytes
  assign ctrl_one_o.reference_as_timestamp_enable = ts_ref_sel;
  assign ctrl_one_o.device_clock_pecl_mode = dev_clk_pecl;
  assign ctrl_one_o.reference_input_pecl_mode = ref_in_pecl;
  assign ctrl_one_o.reference_polarity_invert = ref_invert;
  assign ctrl_two_o.feedback_gain_high = fb_gain_high;
  assign ctrl_two_o.supply_noise_suppress = noise_suppress;
  assign ctrl_two_o.sample_clock_delay = sclk_delay;

  // select and zoom pass straight through
  assign ref_delay_sel_o = reference_delay_select_i;
  assign auto_cal_allowed_o = (reference_delay_select_i == '0);
  assign window_fine_o = reference_window_fine_i;
endmodule

// ---- verilog/clk_ref_pkg.sv ----
// constants and carrier types for the clock and reference control registers
// assumes byte-wide register access from the serial configuration port engine
package clk_ref_pkg;
  localparam int ADDR_W = 15;
  localparam int POS_W = 24;
  localparam int SAMPLE_W = 12;
  localparam logic [ADDR_W-1:0] CLOCK_CONTROL_ONE_OFS = 15'h002A;
  localparam logic [ADDR_W-1:0] CLOCK_CONTROL_TWO_OFS = 15'h002B;
  localparam logic [ADDR_W-1:0] REF_POS_B0_OFS = 15'h002C;
  localparam logic [ADDR_W-1:0] REF_POS_B1_OFS = 15'h002D;
  localparam logic [ADDR_W-1:0] REF_POS_B2_OFS = 15'h002E;
  localparam logic [7:0] CLOCK_CONTROL_ONE_RST = 8'h00;
  localparam logic [7:0] CLOCK_CONTROL_TWO_RST = 8'h11;
  localparam logic [POS_W-1:0] REF_POS_RST = 24'h000000;
  // field positions, clock_control_one
  localparam int TS_REF_BIT = 3;
  localparam int DEV_PECL_BIT = 2;
  localparam int REF_PECL_BIT = 1;
  localparam int REF_INV_BIT = 0;
  // field positions, clock_control_two
  localparam int FB_GAIN_BIT = 4;
  localparam int NOISE_SUPP_BIT = 2;
  localparam int SCLK_DEL_LSB = 0;
  localparam int SCLK_DEL_W = 2;
  localparam int REF_SEL_W = 4;

  typedef struct packed {
    logic reference_as_timestamp_enable;
    logic device_clock_pecl_mode;
    logic reference_input_pecl_mode;
    logic reference_polarity_invert;
  } ctrl_one_t;

  typedef struct packed {
    logic feedback_gain_high;
    logic supply_noise_suppress;
    logic [SCLK_DEL_W-1:0] sample_clock_delay;
  } ctrl_two_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

// ---- verilog/ref_edge_capture.sv ----
// reference edge capture: synchronises the alignment reference and the
// delay-line taps, applies polarity, and latches the tap vector on each rising edge
// assumes taps and reference arrive from outside the clk_i domain
`timescale 1ns/1ps
module ref_edge_capture
  import clk_ref_pkg::*;
#(
  parameter int TAP_W = POS_W
) (
  input wire logic clk_i,                // system clock
  input wire logic rst_i,                // async reset, high
  input wire logic ce_i,                 // clock enable
  input wire logic ref_i,                // raw reference level
  input wire logic [TAP_W-1:0] taps_i,   // raw delay-line taps
  input wire logic invert_i,             // polarity invert
  output logic ref_level_o,              // polarity-corrected reference
  output logic [TAP_W-1:0] pos_o,        // captured position
  output logic pos_valid_o               // an edge has been captured
);
  if (TAP_W < 1 || TAP_W > POS_W) begin : g_bad_tap_w
    $error("TAP_W out of range");
  end

  logic [1:0] ref_sync_ff;
  logic [TAP_W-1:0] tap_meta_ff;
  logic [TAP_W-1:0] tap_sync_ff;
  logic ref_prev_ff;
  logic ref_level_ff;
  logic [TAP_W-1:0] pos_ff;
  logic pos_valid_ff;
  wire ref_pol = ref_sync_ff[1] ^ invert_i;
  wire edge_seen = ref_pol & ~ref_prev_ff;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_sync_ff <= 2'h0;
      tap_meta_ff <= '0;
      tap_sync_ff <= '0;
      ref_prev_ff <= 1'b0;
      ref_level_ff <= 1'b0;
    end else if (ce_i) begin
      ref_sync_ff <= {ref_sync_ff[0], ref_i};
      tap_meta_ff <= taps_i;
      tap_sync_ff <= tap_meta_ff;
      ref_prev_ff <= ref_pol;
      ref_level_ff <= ref_pol;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pos_ff <= '0;
      pos_valid_ff <= 1'b0;
    end else if (ce_i && edge_seen) begin
      pos_ff <= tap_sync_ff;
      pos_valid_ff <= 1'b1;
    end
  end

  assign ref_level_o = ref_level_ff;
  assign pos_o = pos_ff;
  assign pos_valid_o = pos_valid_ff;
endmodule

// ---- sim/clock_sysref_control_regs_monitor.sv ----
// port assertions for the clock and reference control registers
// bound into clock_sysref_control_regs; one clock domain
`timescale 1ns/1ps
module clock_sysref_control_regs_monitor
  import clk_ref_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic ce_i, // enable
  input wire reg_req_t req_i, // request
  input wire logic [7:0] rdata_o, // read data
  input wire logic timestamp_global_enable_i, // ts enable
  input wire logic ddc_bypass_i, // bypass
  input wire logic [REF_SEL_W-1:0] reference_delay_select_i, // select
  input wire logic reference_window_fine_i, // zoom
  input wire logic [SAMPLE_W-1:0] sample_i, // sample in
  input wire logic [SAMPLE_W-1:0] sample_o, // sample out
  input wire ctrl_one_t ctrl_one_o, // fields one
  input wire ctrl_two_t ctrl_two_o, // fields two
  input wire logic [REF_SEL_W-1:0] ref_delay_sel_o, // applied select
  input wire logic auto_cal_allowed_o, // auto cal
  input wire logic window_fine_o // fine step
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire ts_on = ctrl_one_o.reference_as_timestamp_enable && timestamp_global_enable_i && ddc_bypass_i;
  sequence s_rd(a);
    ce_i && req_i.rd && req_i.addr == a;
  endsequence
  sequence s_wr(a);
    ce_i && req_i.wr && req_i.addr == a;
  endsequence
  a_ts_upper_bits: assert property (ce_i |=> sample_o[SAMPLE_W-1:1] == $past(sample_i[SAMPLE_W-1:1]))
    else $error("sample upper bits lost");
  a_ts_off_pass: assert property (ce_i && !ts_on |=> sample_o == $past(sample_i))
    else $error("sample altered with timestamp off");
  a_wr_one_fields: assert property (s_wr(CLOCK_CONTROL_ONE_OFS) |=> ctrl_one_o == $past(req_i.wdata[3:0]))
    else $error("first control write not applied");
  a_wr_two_fields: assert property (s_wr(CLOCK_CONTROL_TWO_OFS) |=>
    ctrl_two_o == {$past(req_i.wdata[4]), $past(req_i.wdata[2:0])})
    else $error("second control write not applied");
  a_rd_one_data: assert property (s_rd(CLOCK_CONTROL_ONE_OFS) |=> rdata_o[3:0] == $past(ctrl_one_o))
    else $error("first control read wrong");
  a_rd_two_data: assert property (s_rd(CLOCK_CONTROL_TWO_OFS) |=>
    rdata_o[4] == $past(ctrl_two_o[3]) && rdata_o[2:0] == $past(ctrl_two_o[2:0]))
    else $error("second control read wrong");
  a_rd_data_hold: assert property (!(ce_i && req_i.rd) |=> $stable(rdata_o))
    else $error("read data moved without read");
  a_sel_pass_cal: assert property (ref_delay_sel_o == reference_delay_select_i &&
    auto_cal_allowed_o == (reference_delay_select_i == 4'h0))
    else $error("delay select or auto cal wrong");
  a_fine_step_pass: assert property (window_fine_o == reference_window_fine_i)
    else $error("fine step not passed");
endmodule
bind clock_sysref_control_regs clock_sysref_control_regs_monitor u_mon (.*);

// ---- sim/test_clock_sysref_control_regs.sv ----
// self-checking bench for the clock and reference control registers
// drives all ports itself at the falling clock edge
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module test_clock_sysref_control_regs
  import clk_ref_pkg::*;
;
  logic clk_i, rst_i, ce_i, timestamp_global_enable_i, ddc_bypass_i, reference_window_fine_i, ref_i;
  logic auto_cal_allowed_o, window_fine_o, pos_valid_o, ref_aligned_o;
  reg_req_t req_i;
  logic [7:0] rdata_o, v;
  logic [3:0] reference_delay_select_i, ref_delay_sel_o;
  logic [23:0] ref_taps_i;
  logic [11:0] sample_i, sample_o;
  ctrl_one_t ctrl_one_o;
  ctrl_two_t ctrl_two_o;
  int fails, cmp_count;
  clock_sysref_control_regs u_dut (.*);
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req_i = '{1'b1, 1'b0, a, d};
    @(negedge clk_i);
    req_i.wr = 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(negedge clk_i);
    req_i = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_i);
    req_i.rd = 1'b0;
    d = rdata_o;
  endtask
  task automatic t_reset();
    `CHK(ctrl_one_o, 4'h0)
    `CHK(ctrl_two_o, 4'h9)
    `CHK(pos_valid_o, 1'b0)
    rd(CLOCK_CONTROL_TWO_OFS, v);
    `CHK(v, 8'h11)
  endtask
  task automatic t_regs();
    logic [7:0] d1 [2] = '{8'hF5, 8'h0A};
    logic [7:0] d2 [2] = '{8'hEE, 8'h15};
    for (int i = 0; i < 2; i++) begin
      wr(CLOCK_CONTROL_ONE_OFS, d1[i]);
      wr(CLOCK_CONTROL_TWO_OFS, d2[i]);
      `CHK(ctrl_one_o, d1[i][3:0])
      `CHK(ctrl_two_o, {d2[i][4], d2[i][2:0]})
      rd(CLOCK_CONTROL_ONE_OFS, v);
      `CHK(v, d1[i])
      rd(CLOCK_CONTROL_TWO_OFS, v);
      `CHK(v, d2[i])
    end
    ce_i = 1'b0;
    wr(CLOCK_CONTROL_ONE_OFS, 8'h33);
    ce_i = 1'b1;
    rd(15'h0040, v);
    `CHK(v, 8'h00)
    `CHK(ctrl_one_o, 4'hA)
  endtask
  task automatic t_pos();
    ref_taps_i = 24'hA5C33C;
    repeat (4) @(negedge clk_i);
    ref_i = 1'b1;
    repeat (5) @(negedge clk_i);
    `CHK(pos_valid_o, 1'b1)
    `CHK(ref_aligned_o, 1'b1)
    wr(REF_POS_B0_OFS, 8'hFF);
    rd(REF_POS_B0_OFS, v);
    `CHK(v, 8'h3C)
    rd(REF_POS_B1_OFS, v);
    `CHK(v, 8'hC3)
    rd(REF_POS_B2_OFS, v);
    `CHK(v, 8'hA5)
    `CHK(auto_cal_allowed_o, 1'b1)
    reference_delay_select_i = 4'h9;
    reference_window_fine_i = 1'b1;
    @(negedge clk_i);
    `CHK({ref_delay_sel_o, auto_cal_allowed_o, window_fine_o}, 6'h25)
  endtask
  task automatic t_ts();
    timestamp_global_enable_i = 1'b1;
    sample_i = 12'hFFF;
    wr(CLOCK_CONTROL_ONE_OFS, 8'h09);
    repeat (4) @(negedge clk_i);
    `CHK(ref_aligned_o, 1'b0)
    `CHK(sample_o, 12'hFFE)
    ddc_bypass_i = 1'b0;
    repeat (2) @(negedge clk_i);
    `CHK(sample_o, 12'hFFF)
  endtask
  task automatic print_verdict();
    if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {rst_i, ce_i, ddc_bypass_i} = 3'h7;
    {timestamp_global_enable_i, reference_window_fine_i, ref_i} = 3'h0;
    {req_i, reference_delay_select_i, ref_taps_i, sample_i} = '0;
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    t_reset();
    t_regs();
    t_pos();
    t_ts();
    print_verdict();
  end
  initial begin
    #20000;
    fails++;
    print_verdict();
  end
endmodule
